// ---- nfc_dev_model.sv ----
// behavioural nand device facing the host sequencer
// assumes host pins come straight in; io not driven reads as inverted last value
module nfc_dev_model #(
  parameter logic [9:0] bad_block = 10'h005,
  parameter int busy_ns = 300
) (
  input wire nfc_pkg::nfc_pins_type pins, // host pins
  input wire logic [15:0] io_in, // host io drive
  output logic [15:0] io_out, // device io level
  output logic busy_n, // ready/busy
  output logic [7:0] last_cmd, // last command
  output logic [31:0] addr_seen, // address bytes, first in low byte
  output logic [15:0] data_seen, // last data word
  output logic [2:0] addr_cnt, // address bytes taken
  output logic prog_done // array op started
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] blk;
  assign blk = {addr_seen[31:24], addr_seen[23:22]};
  initial begin
    io_out = 16'h5a5a;
    busy_n = 1'b1;
    prog_done = 1'b0;
    addr_cnt = 3'h0;
  end
  always @(posedge pins.write_strobe_n) begin
    if (!pins.chip_select_n && pins.cmd_latch) begin
      last_cmd = io_in[7:0];
      addr_cnt = 3'h0;
    end else if (!pins.chip_select_n && pins.addr_latch && addr_cnt < 3'h4) begin
      addr_seen[addr_cnt*8 +: 8] = io_in[7:0];
      addr_cnt = addr_cnt + 3'h1;
    end else if (!pins.chip_select_n) begin
      data_seen = io_in;
    end
  end
  always @(posedge pins.write_strobe_n) begin
    if (pins.cmd_latch && !pins.chip_select_n) begin
      prog_done = pins.write_protect_n && (io_in[7:0] == 8'h10 || io_in[7:0] == 8'hd0);
      if (prog_done) begin
        busy_n = 1'b0;
        #busy_ns busy_n = 1'b1;
      end
    end
  end
  always @(negedge pins.read_strobe_n) begin
    if (!pins.chip_select_n) begin
      #20 io_out = (blk == bad_block) ? 16'h0000 : 16'hffff;
    end
  end
  always @(posedge pins.read_strobe_n) begin
    io_out = ~io_out;
  end
endmodule

// ---- nfc_host.sv ----
// host-side nand flash pin sequencer: command, address, data cycles and defect guard
// assumes one 125 MHz clock; pins are asynchronous and pass nfc_sync
`include "nfc_map.svh"

// Operation
// - low eight io lines are a two-way port for commands, addresses, data
// - high eight io lines carry only the upper data byte in wide mode
// - byte-wide address: four cycles, cycle two has four bits, upper lines low
// - word-wide address: four cycles, cycle two has three bits, upper lines low
// - never program or erase a block that carries a defect marker
// - block is defective when most marker bits read as zero
// - check marker on first and last page before program or erase
// - scan blocks into a defect table before modifying any block
// - commands go with select low, command latch high, address latch low, read strobe high
// - hold write protect high while issuing program or erase sequences
// - commands and addresses always on the low eight io lines
module nfc_host (
  input wire logic mclk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic bus_wide16, // device is word-wide
  input wire logic req_valid, // request present
  input wire nfc_pkg::nfc_req_type req, // request contents
  output logic req_ready, // request may be taken
  output logic rsp_valid, // response pulse
  output nfc_pkg::nfc_rsp_type rsp, // response contents
  output nfc_pkg::nfc_pins_type pins, // control pins
  input wire logic busy_n, // ready/busy pin, low while busy
  input wire logic [7:0] io_low_byte_in, // io low byte level
  output logic [7:0] io_low_byte_out, // io low byte drive value
  output logic io_low_byte_oe, // io low byte driven when high
  input wire logic [7:0] io_high_byte_in, // io high byte level
  output logic [7:0] io_high_byte_out, // io high byte drive value
  output logic io_high_byte_oe // io high byte driven when high
);

  localparam int t_setup = (`NFC_T_SETUP_NS * 1000 + `NFC_CLK_PS - 1) / `NFC_CLK_PS;
  localparam int t_strobe = (`NFC_T_STROBE_NS * 1000 + `NFC_CLK_PS - 1) / `NFC_CLK_PS;
  localparam int t_hold = (`NFC_T_HOLD_NS * 1000 + `NFC_CLK_PS - 1) / `NFC_CLK_PS;
  localparam int t_access = (`NFC_T_ACCESS_NS * 1000 + `NFC_CLK_PS - 1) / `NFC_CLK_PS + `NFC_SYNC_DEPTH +
                            `NFC_READ_PIPE;
  localparam int t_busy = (`NFC_T_BUSY_NS * 1000 + `NFC_CLK_PS - 1) / `NFC_CLK_PS;

  typedef enum logic [2:0] {
    st_idle,
    st_setup,
    st_wstrobe,
    st_hold,
    st_rstrobe,
    st_busy_gap,
    st_busy_wait,
    st_done
  } nfc_state_type;

  nfc_state_type state;
  nfc_pkg::nfc_req_type cur;
  logic [3:0] tmr;
  logic [1:0] addr_idx;
  logic modify_seq;
  logic refuse_seq;
  logic busy_sync;
  logic [15:0] io_sync;
  logic [`NFC_BLOCKS-1:0] first_seen;
  logic [`NFC_BLOCKS-1:0] last_seen;
  logic [`NFC_BLOCKS-1:0] bad;
  logic [15:0] next_word;
  logic next_defect;
  logic next_refuse;
  logic next_is_modify;
  logic [4:0] zeros;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  nfc_sync #(.width(17)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .din({busy_n, io_high_byte_in, io_low_byte_in}),
    .init(17'h0_0000),
    .dout({busy_sync, io_sync})
  );

  ////////////////////////////////////////////////////////////////////////////
  // address byte formatting
  function automatic logic [7:0] addr_byte(input logic [1:0] idx, input logic w16,
                                           input nfc_pkg::nfc_req_type r);
    logic [31:0] packed8;
    logic [31:0] packed16;
    packed8 = {r.block, r.page, 4'h0, r.col};
    packed16 = {r.block, r.page, 5'h00, r.col[`NFC_COL16_W-1:0]};
    return w16 ? packed16[idx*8 +: 8] : packed8[idx*8 +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // defect decisions
  always_comb begin
    next_word = bus_wide16 ? io_sync : {8'h00, io_sync[7:0]};
    zeros = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (i < 8 || bus_wide16) begin
        zeros = zeros + {4'h0, ~io_sync[i]};
      end
    end
    next_defect = bus_wide16 ? (zeros > `NFC_MAJ16) : (zeros > {1'b0, `NFC_MAJ8});
    next_is_modify = req.data[7:0] == `NFC_CMD_PROG || req.data[7:0] == `NFC_CMD_RAND_IN ||
                     req.data[7:0] == `NFC_CMD_REPROG || req.data[7:0] == `NFC_CMD_ERASE;
    next_refuse = 1'b0;
    if (req.kind == nfc_pkg::nfc_op_addr && modify_seq) begin
      next_refuse = !first_seen[req.block] || !last_seen[req.block] || bad[req.block];
    end else if (req.kind == nfc_pkg::nfc_op_cmd && refuse_seq) begin
      next_refuse = req.data[7:0] == `NFC_CMD_PROG_GO || req.data[7:0] == `NFC_CMD_CACHE_GO ||
                    req.data[7:0] == `NFC_CMD_ERASE_GO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and cycle timer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_idle;
      cur <= '0;
      tmr <= 4'h0;
      addr_idx <= 2'h0;
      req_ready <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            cur <= req;
            req_ready <= 1'b0;
            addr_idx <= 2'h0;
            if (next_refuse) begin
              state <= st_done;
            end else if (req.kind == nfc_pkg::nfc_op_read) begin
              tmr <= 4'(t_access - 1);
              state <= st_rstrobe;
            end else if (req.kind == nfc_pkg::nfc_op_wait) begin
              tmr <= 4'(t_busy - 1);
              state <= st_busy_gap;
            end else begin
              tmr <= 4'(t_setup - 1);
              state <= st_setup;
            end
          end
        end
        st_setup: begin
          if (tmr == 4'h0) begin
            tmr <= 4'(t_strobe - 1);
            state <= st_wstrobe;
          end else begin
            tmr <= tmr - 4'h1;
          end
        end
        st_wstrobe: begin
          if (tmr == 4'h0) begin
            tmr <= 4'(t_hold - 1);
            state <= st_hold;
          end else begin
            tmr <= tmr - 4'h1;
          end
        end
        st_hold: begin
          if (tmr != 4'h0) begin
            tmr <= tmr - 4'h1;
          end else if (cur.kind == nfc_pkg::nfc_op_addr && addr_idx != `NFC_LAST_ADDR_CYCLE) begin
            addr_idx <= addr_idx + 2'h1;
            tmr <= 4'(t_setup - 1);
            state <= st_setup;
          end else begin
            state <= st_done;
          end
        end
        st_rstrobe: begin
          if (tmr == 4'h0) begin
            tmr <= 4'(t_hold - 1);
            state <= st_hold;
          end else begin
            tmr <= tmr - 4'h1;
          end
        end
        st_busy_gap: begin
          if (tmr == 4'h0) begin
            state <= st_busy_wait;
          end else begin
            tmr <= tmr - 4'h1;
          end
        end
        st_busy_wait: begin
          if (busy_sync) begin
            state <= st_done;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pins <= '{cmd_latch: 1'b0, addr_latch: 1'b0, chip_select_n: 1'b1,
                write_strobe_n: 1'b1, read_strobe_n: 1'b1, write_protect_n: 1'b0};
      io_low_byte_out <= 8'h00;
      io_low_byte_oe <= 1'b0;
      io_high_byte_out <= 8'h00;
      io_high_byte_oe <= 1'b0;
    end else begin
      pins.chip_select_n <= state == st_idle || state == st_done;
      pins.cmd_latch <= cur.kind == nfc_pkg::nfc_op_cmd && (state == st_setup || state == st_wstrobe ||
                        state == st_hold);
      pins.addr_latch <= cur.kind == nfc_pkg::nfc_op_addr && (state == st_setup || state == st_wstrobe ||
                         state == st_hold);
      pins.write_strobe_n <= state != st_wstrobe;
      pins.read_strobe_n <= state != st_rstrobe;
      pins.write_protect_n <= modify_seq;
      io_low_byte_oe <= state == st_setup || state == st_wstrobe || state == st_hold &&
                        cur.kind != nfc_pkg::nfc_op_read;
      io_high_byte_oe <= bus_wide16 && cur.kind == nfc_pkg::nfc_op_write && (state == st_setup ||
                         state == st_wstrobe || state == st_hold);
      io_low_byte_out <= cur.kind == nfc_pkg::nfc_op_addr ? addr_byte(addr_idx, bus_wide16, cur)
                                                          : cur.data[7:0];
      io_high_byte_out <= cur.kind == nfc_pkg::nfc_op_write ? cur.data[15:8] : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modify-sequence tracking
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      modify_seq <= 1'b0;
      refuse_seq <= 1'b0;
    end else if (state == st_idle && req_valid && req_ready) begin
      if (req.kind == nfc_pkg::nfc_op_cmd && req.data[7:0] != `NFC_CMD_STATUS) begin
        if (next_is_modify) begin
          modify_seq <= 1'b1;
          refuse_seq <= 1'b0;
        end else if (req.data[7:0] != `NFC_CMD_PROG_GO && req.data[7:0] != `NFC_CMD_CACHE_GO &&
                     req.data[7:0] != `NFC_CMD_ERASE_GO) begin
          modify_seq <= 1'b0;
          refuse_seq <= 1'b0;
        end
      end else if (req.kind == nfc_pkg::nfc_op_addr && next_refuse) begin
        refuse_seq <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response and defect table
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
      first_seen <= '0;
      last_seen <= '0;
      bad <= '0;
    end else begin
      rsp_valid <= state == st_done;
      if (state == st_idle && req_valid && req_ready) begin
        rsp.refused <= next_refuse;
        rsp.defect <= 1'b0;
      end
      if (state == st_rstrobe && tmr == 4'h0) begin
        rsp.data <= next_word;
        if (cur.check) begin
          rsp.defect <= next_defect;
          if (next_defect) begin
            bad[cur.block] <= 1'b1;
          end
          if (cur.page == `NFC_FIRST_PAGE) begin
            first_seen[cur.block] <= 1'b1;
          end
          if (cur.page == `NFC_LAST_PAGE) begin
            last_seen[cur.block] <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// ---- nfc_host_asserts.sv ----
// pin sequencing checks for the nand host sequencer
// assumes it is bound to nfc_host and sees its ports only
module nfc_host_asserts (
  input wire logic mclk, // clock
  input wire logic reset_n, // reset, active low
  input wire logic bus_wide16, // word-wide device
  input wire logic req_ready, // idle
  input wire nfc_pkg::nfc_pins_type pins, // control pins
  input wire logic [7:0] io_low_byte_out, // low byte drive
  input wire logic io_low_byte_oe, // low byte enable
  input wire logic io_high_byte_oe // high byte enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  property p_standby;
    req_ready |-> pins.chip_select_n;
  endproperty
  a_standby: assert property (p_standby) else $error("select low while idle");
  property p_cmd;
    pins.cmd_latch |-> !pins.addr_latch && !pins.chip_select_n && pins.read_strobe_n && io_low_byte_oe;
  endproperty
  a_cmd: assert property (p_cmd) else $error("bad command cycle pins");
  property p_addr;
    pins.addr_latch |-> !pins.cmd_latch && !pins.chip_select_n && pins.read_strobe_n && io_low_byte_oe;
  endproperty
  a_addr: assert property (p_addr) else $error("bad address cycle pins");
  property p_hold;
    $rose(pins.write_strobe_n) |-> $stable(io_low_byte_out) && $stable(pins.cmd_latch) && !pins.chip_select_n;
  endproperty
  a_hold: assert property (p_hold) else $error("value moved at strobe rise");
  property p_strobe;
    $fell(pins.write_strobe_n) |-> !pins.write_strobe_n[*4] ##1 pins.write_strobe_n[*2];
  endproperty
  a_strobe: assert property (p_strobe) else $error("write strobe width wrong");
  property p_read_len;
    $fell(pins.read_strobe_n) |-> !pins.read_strobe_n[*8] ##1 pins.read_strobe_n;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read strobe width wrong");
  property p_read_drive;
    !pins.read_strobe_n |-> !io_low_byte_oe && !io_high_byte_oe && pins.write_strobe_n;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("host drives during read");
  property p_wp;
    $fell(pins.write_strobe_n) && pins.cmd_latch && (io_low_byte_out == 8'h10 || io_low_byte_out == 8'hd0)
      |-> pins.write_protect_n;
  endproperty
  a_wp: assert property (p_wp) else $error("protect low at confirm");
  property p_high;
    (pins.cmd_latch || pins.addr_latch || !bus_wide16) |-> !io_high_byte_oe;
  endproperty
  a_high: assert property (p_high) else $error("high byte driven");
endmodule
bind nfc_host nfc_host_asserts u_nfc_host_asserts (.mclk(mclk), .reset_n(reset_n), .bus_wide16(bus_wide16),
  .req_ready(req_ready), .pins(pins), .io_low_byte_out(io_low_byte_out), .io_low_byte_oe(io_low_byte_oe),
  .io_high_byte_oe(io_high_byte_oe));

// ---- nfc_map.svh ----
// named constants for the nand host sequencer: timing, commands, field sizes
// assumes a single 125 MHz clock; included by bare name wherever needed
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH

`define NFC_CLK_PS 8000
`define NFC_T_SETUP_NS 15
`define NFC_T_STROBE_NS 25
`define NFC_T_HOLD_NS 10
`define NFC_T_ACCESS_NS 20
`define NFC_T_BUSY_NS 100
`define NFC_SYNC_DEPTH 3
// read strobe pin register plus synchroniser output stage
`define NFC_READ_PIPE 2

`define NFC_COL8_W 12
`define NFC_COL16_W 11
`define NFC_PAGE_W 6
`define NFC_BLOCK_W 10
`define NFC_BLOCKS 1024
`define NFC_FIRST_PAGE 6'h00
`define NFC_LAST_PAGE 6'h3f
`define NFC_LAST_ADDR_CYCLE 2'h3

`define NFC_CMD_PROG 8'h80
`define NFC_CMD_RAND_IN 8'h85
`define NFC_CMD_REPROG 8'h8b
`define NFC_CMD_ERASE 8'h60
`define NFC_CMD_PROG_GO 8'h10
`define NFC_CMD_CACHE_GO 8'h15
`define NFC_CMD_ERASE_GO 8'hd0
`define NFC_CMD_STATUS 8'h70

`define NFC_MAJ8 4'h4
`define NFC_MAJ16 5'h08
`define NFC_ONES16 16'hffff

`endif

// ---- nfc_pkg.sv ----
// types shared by the nand host sequencer
// assumes nfc_map.svh supplies the field widths
`include "nfc_map.svh"

package nfc_pkg;

  typedef enum logic [2:0] {
    nfc_op_cmd,
    nfc_op_addr,
    nfc_op_write,
    nfc_op_read,
    nfc_op_wait
  } nfc_kind_type;

  typedef struct packed {
    nfc_kind_type kind;
    logic [15:0] data;
    logic [`NFC_COL8_W-1:0] col;
    logic [`NFC_PAGE_W-1:0] page;
    logic [`NFC_BLOCK_W-1:0] block;
    logic check;
  } nfc_req_type;

  typedef struct packed {
    logic [15:0] data;
    logic defect;
    logic refused;
  } nfc_rsp_type;

  typedef struct packed {
    logic cmd_latch;
    logic addr_latch;
    logic chip_select_n;
    logic write_strobe_n;
    logic read_strobe_n;
    logic write_protect_n;
  } nfc_pins_type;

endpackage

// ---- nfc_sync.sv ----
// three-stage input synchroniser; output follows once stages two and three agree
// assumes inputs are asynchronous to mclk
module nfc_sync #(
  parameter int width = 1
) (
  input wire logic mclk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [width-1:0] din, // asynchronous input
  input wire logic [width-1:0] init, // unused; dout resets to zero regardless
  output logic [width-1:0] dout // filtered synchronous level
);

  logic [width-1:0] stage1;
  logic [width-1:0] stage2;
  logic [width-1:0] stage3;

  for (genvar i = 0; i < width; i++) begin : g_bit
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        stage1[i] <= 1'b0;
        stage2[i] <= 1'b0;
        stage3[i] <= 1'b0;
      end else begin
        stage1[i] <= din[i];
        stage2[i] <= stage1[i];
        stage3[i] <= stage2[i];
      end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        dout[i] <= 1'b0;
      end else if (stage2[i] == stage3[i]) begin
        dout[i] <= stage3[i];
      end
    end
  end

  // init is reserved for callers that want a nonzero idle level; all bits ignored
  logic unused_init;
  assign unused_init = ^init;

endmodule

// ---- test_nfc_host.sv ----
// self-checking bench for the nand host sequencer
// assumes nfc_dev_model as the far side and the bound checker
module test_nfc_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset_n, bus_wide16, req_valid, req_ready, rsp_valid, busy_n, lo_oe, hi_oe, prog_done;
  nfc_pkg::nfc_req_type req;
  nfc_pkg::nfc_rsp_type rsp;
  nfc_pkg::nfc_pins_type pins;
  logic [7:0] lo_out, hi_out, last_cmd;
  logic [15:0] dev_io, data_seen;
  logic [31:0] addr_seen;
  logic [2:0] addr_cnt;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  nfc_host u_nfc_host (.mclk(mclk), .reset_n(reset_n), .bus_wide16(bus_wide16), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .busy_n(busy_n),
    .io_low_byte_in(lo_oe ? lo_out : dev_io[7:0]), .io_low_byte_out(lo_out), .io_low_byte_oe(lo_oe),
    .io_high_byte_in(hi_oe ? hi_out : dev_io[15:8]), .io_high_byte_out(hi_out), .io_high_byte_oe(hi_oe));
  nfc_dev_model u_nfc_dev_model (.pins(pins), .io_in({hi_out, lo_out}), .io_out(dev_io), .busy_n(busy_n),
    .last_cmd(last_cmd), .addr_seen(addr_seen), .data_seen(data_seen), .addr_cnt(addr_cnt),
    .prog_done(prog_done));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run_req(input nfc_pkg::nfc_kind_type k, input logic [15:0] d, input logic [9:0] b,
    input logic [5:0] p, input logic [11:0] c, input logic chk);
    int n = 0;
    @(negedge mclk);
    req = '{k, d, c, p, b, chk};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    cmp("rsp_valid", 32'h0000_0001, {31'h0, rsp_valid});
  endtask
  task send_cmd(input logic [7:0] c);
    run_req(nfc_pkg::nfc_op_cmd, {8'h00, c}, '0, '0, '0, 1'b0);
  endtask
  task send_addr(input logic [9:0] b, input logic [5:0] p, input logic [11:0] c);
    run_req(nfc_pkg::nfc_op_addr, '0, b, p, c, 1'b0);
  endtask
  task check_page(input logic [9:0] b, input logic [5:0] p, input logic def, input logic [15:0] data);
    send_cmd(8'h00);
    send_addr(b, p, '0);
    run_req(nfc_pkg::nfc_op_read, '0, b, p, '0, 1'b1);
    cmp("defect", {31'h0, def}, {31'h0, rsp.defect});
    cmp("read data", {16'h0, data}, {16'h0, rsp.data});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_cmd;
    send_cmd(8'h70);
    cmp("command", 32'h0000_0070, {24'h0, last_cmd});
    cmp("refused", 32'h0, {31'h0, rsp.refused});
    $display("t_cmd done");
  endtask
  task automatic t_addr(input logic w);
    logic [27:0] a;
    logic [31:0] exp;
    bus_wide16 = w;
    a = w ? {1'b0, 10'h2d3, 6'h2b, 11'h1a5} : {10'h2d3, 6'h2b, 12'h9a5};
    exp = w ? {a[26:19], a[18:11], 5'h00, a[10:8], a[7:0]} : {a[27:20], a[19:12], 4'h0, a[11:8], a[7:0]};
    send_cmd(8'h00);
    send_addr(10'h2d3, 6'h2b, 12'h9a5);
    cmp("address bytes", exp, addr_seen);
    cmp("address count", 32'h0000_0004, {29'h0, addr_cnt});
    $display("t_addr done");
  endtask
  task t_marker;
    bus_wide16 = 1'b1;
    check_page(10'h033, 6'h00, 1'b0, 16'hffff);
    bus_wide16 = 1'b0;
    check_page(10'h033, 6'h3f, 1'b0, 16'h00ff);
    $display("t_marker done");
  endtask
  task t_refuse;
    send_cmd(8'h80);
    send_addr(10'h100, 6'h00, '0);
    cmp("refused", 32'h0000_0001, {31'h0, rsp.refused});
    cmp("address count", 32'h0, {29'h0, addr_cnt});
    send_cmd(8'h10);
    cmp("refused", 32'h0000_0001, {31'h0, rsp.refused});
    cmp("started", 32'h0, {31'h0, prog_done});
    send_cmd(8'h00);
    $display("t_refuse done");
  endtask
  task t_bad;
    check_page(10'h005, 6'h00, 1'b1, 16'h0000);
    check_page(10'h005, 6'h3f, 1'b1, 16'h0000);
    send_cmd(8'h60);
    send_addr(10'h005, 6'h00, '0);
    cmp("refused", 32'h0000_0001, {31'h0, rsp.refused});
    send_cmd(8'h00);
    $display("t_bad done");
  endtask
  task automatic t_modify(input logic [7:0] start, input logic [7:0] go);
    send_cmd(start);
    send_addr(10'h033, 6'h01, '0);
    cmp("refused", 32'h0, {31'h0, rsp.refused});
    if (start == 8'h80) begin
      run_req(nfc_pkg::nfc_op_write, 16'h1234, '0, '0, '0, 1'b0);
      cmp("data byte", 32'h0000_0034, {24'h0, data_seen[7:0]});
    end
    send_cmd(go);
    cmp("started", 32'h0000_0001, {31'h0, prog_done});
    cmp("busy", 32'h0, {31'h0, busy_n});
    run_req(nfc_pkg::nfc_op_wait, '0, '0, '0, '0, 1'b0);
    cmp("ready", 32'h0000_0001, {31'h0, busy_n});
    $display("t_modify done");
  endtask
  initial begin
    reset_n = 1'b0;
    bus_wide16 = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    t_cmd();
    t_addr(1'b0);
    t_addr(1'b1);
    t_marker();
    t_refuse();
    t_bad();
    t_modify(8'h80, 8'h10);
    t_modify(8'h60, 8'hd0);
    complete_run();
  end
endmodule
